// [inc/prs_map.svh]
/*
 * Offsets, field positions, masks and channel numbers of the pin route unit.
 * Assumes inclusion by bare name before the modules that use it.
 */
`ifndef PRS_MAP_SVH
`define PRS_MAP_SVH
// Register indices
`define PRS_IDX_LUT_EVT 2'h0
`define PRS_IDX_SERIAL 2'h1
`define PRS_IDX_TIMER_A 2'h2
`define PRS_IDX_TIMER_B 2'h3
// Byte addresses, four times the index
`define PRS_ADDR_LUT_EVT 4'h0
`define PRS_ADDR_SERIAL 4'h4
`define PRS_ADDR_TIMER_A 4'h8
`define PRS_ADDR_TIMER_B 4'hC
// Reset value and writable bits per register
`define PRS_RESET_VAL 8'h00
`define PRS_MASK_LUT_EVT 8'h37
`define PRS_MASK_SERIAL 8'h15
`define PRS_MASK_TIMER_A 8'h3F
`define PRS_MASK_TIMER_B 8'h01
// Field positions
`define PRS_BIT_EVENT_LO 0
`define PRS_BIT_EVENT_HI 2
`define PRS_BIT_TABLE0 4
`define PRS_BIT_TABLE1 5
`define PRS_BIT_ASYNC 0
`define PRS_BIT_PERIPH 2
`define PRS_BIT_TWO_WIRE 4
`define PRS_BIT_TIMER_B 0
// Timer A waves; from this one up, split mode only
`define PRS_WAVE_COUNT 6
`define PRS_WAVE_SPLIT_LO 3
// Channel numbers on the routed vectors
`define PRS_CH_TABLE0 0
`define PRS_CH_TABLE1 1
`define PRS_CH_TXD 2
`define PRS_CH_RXD 3
`define PRS_CH_XCK 4
`define PRS_CH_MOSI 5
`define PRS_CH_SS 8
`define PRS_CH_SDA 9
`define PRS_CH_SCL 10
`define PRS_CH_WAVE0 11
`define PRS_CH_TIMER_B 17
`define PRS_CH_COUNT 18
`define PRS_EVENT_COUNT 3
`endif

// [inc/prs_pkg.sv]
/*
 * Types of the pin route unit.
 * Assumes nothing of its surroundings.
 */
`default_nettype none
package prs_pkg;
    typedef logic [7:0]  prs_byte_t;  // One route register
    typedef logic [31:0] prs_word_t;  // Bus data word
    typedef logic [1:0]  prs_index_t; // Register index
    // Bus slave states
    typedef enum {bus_idle, bus_answer} prs_bus_state_t;
endpackage
`default_nettype wire

// [inc/prs_reg_if.sv]
/*
 * Internal register access between bus slave and register file.
 * Assumes prs_pkg is compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
interface prs_reg_if;
    logic               wr_stb; // Write pulse, answer cycle
    prs_pkg::prs_index_t index; // Register index
    prs_pkg::prs_byte_t  wdata;  // Write byte
    prs_pkg::prs_byte_t  rdata;  // Read byte of index
    // Bus side
    modport slave_side (output wr_stb, output index, output wdata, input rdata);
    // Register side
    modport reg_side (input wr_stb, input index, input wdata, output rdata);
endinterface
`default_nettype wire

// [rtl/prs_avmm_slave.sv]
/*
 * Avalon-MM slave with waitrequest for the route registers.
 * Assumes a master that holds its request until waitrequest is low.
 */
`timescale 1ns/1ps
`default_nettype none
`include "prs_map.svh"
module prs_avmm_slave #(
    parameter int ADDR_W = 4
) (
    input  wire logic               sys_clk,
    input  wire logic               rst_b,
    input  wire logic [ADDR_W-1:0]  avm_address,
    input  wire logic               avm_read,
    input  wire logic               avm_write,
    input  wire prs_pkg::prs_word_t avm_writedata,
    input  wire logic [3:0]         avm_byteenable,
    output var prs_pkg::prs_word_t  avm_readdata,
    output var logic                avm_waitrequest,
    prs_reg_if.slave_side           regs
);
    import prs_pkg::*;
    prs_bus_state_t state; // Handshake state
    logic           hit;   // Aligned word inside map
    // Refuse address buses too narrow for the map
    if (ADDR_W < 4)
    begin : g_chk
        $error("ADDR_W below 4");
    end
    // Decode aligned word, upper bits zero
    assign hit = (avm_address[1:0] == 2'h0) && ((avm_address >> 4) == '0);
    assign regs.index = avm_address[3:2];
    assign regs.wdata = avm_writedata[7:0];
    // Write lands at the edge that ends the answer cycle
    assign regs.wr_stb = (state == bus_answer) && avm_write && hit
                         && avm_byteenable[0];
    // One wait cycle, then one answer cycle
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= bus_idle;
            avm_waitrequest <= 1'b1;
        end
        else
        begin
            case (state)
                bus_idle:
                    if (avm_read || avm_write)
                    begin
                        state <= bus_answer;
                        avm_waitrequest <= 1'b0;
                    end
                bus_answer:
                begin
                    state <= bus_idle;
                    avm_waitrequest <= 1'b1;
                end
                default:
                begin
                    state <= bus_idle;
                    avm_waitrequest <= 1'b1;
                end
            endcase
        end
    end
    // Read data captured for the answer cycle; unmapped reads zero
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            avm_readdata <= 32'h0;
        else if (state == bus_idle && avm_read)
            avm_readdata <= hit ? {24'h0, regs.rdata} : 32'h0;
    end
endmodule
`default_nettype wire

// [rtl/prs_route_cell.sv]
/*
 * One routed function: default or alternative pin, both ways.
 * Assumes the select is stable from the register file.
 */
`timescale 1ns/1ps
`default_nettype none
module prs_route_cell (
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic alt_sel,
    input  wire logic fn_out,
    input  wire logic fn_oe,
    input  wire logic def_in,
    input  wire logic alt_in,
    output var logic  fn_in,
    output var logic  def_out,
    output var logic  def_oe,
    output var logic  alt_out,
    output var logic  alt_oe
);
    // Unselected pin is released, so it falls back to port control
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fn_in <= 1'b0;
            def_out <= 1'b0;
            def_oe <= 1'b0;
            alt_out <= 1'b0;
            alt_oe <= 1'b0;
        end
        else
        begin
            def_out <= fn_out & ~alt_sel;
            def_oe <= fn_oe & ~alt_sel;
            alt_out <= fn_out & alt_sel;
            alt_oe <= fn_oe & alt_sel;
            fn_in <= alt_sel ? alt_in : def_in;
        end
    end
endmodule
`default_nettype wire

// [rtl/prs_pin_route_unit.sv]
/*
 * Pin route unit: four route registers on Avalon-MM steer
 * peripheral functions between default and alternative pins,
 * and enable the three event output pins.
 * Assumes pin and peripheral signals synchronous to sys_clk.
 */
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "prs_map.svh"
module prs_pin_route_unit #(
    parameter int ADDR_W = 4
) (
    input  wire logic                      sys_clk,
    input  wire logic                      rst_b,
    input  wire logic [ADDR_W-1:0]         avm_address,
    input  wire logic                      avm_read,
    input  wire logic                      avm_write,
    input  wire prs_pkg::prs_word_t        avm_writedata,
    input  wire logic [3:0]                avm_byteenable,
    output var prs_pkg::prs_word_t         avm_readdata,
    output var logic                       avm_waitrequest,
    input  wire logic                      timer_a_split,
    input  wire logic [`PRS_CH_COUNT-1:0]  fn_out,
    input  wire logic [`PRS_CH_COUNT-1:0]  fn_oe,
    output var logic [`PRS_CH_COUNT-1:0]   fn_in,
    input  wire logic [`PRS_CH_COUNT-1:0]  def_pin_in,
    input  wire logic [`PRS_CH_COUNT-1:0]  alt_pin_in,
    output var logic [`PRS_CH_COUNT-1:0]   def_pin_out,
    output var logic [`PRS_CH_COUNT-1:0]   def_pin_oe,
    output var logic [`PRS_CH_COUNT-1:0]   alt_pin_out,
    output var logic [`PRS_CH_COUNT-1:0]   alt_pin_oe,
    input  wire logic [`PRS_EVENT_COUNT-1:0] event_in,
    output var logic [`PRS_EVENT_COUNT-1:0]  event_pin_out,
    output var logic [`PRS_EVENT_COUNT-1:0]  event_pin_oe
);
    import prs_pkg::*;

    // Route registers
    prs_byte_t route_a; // Tables and event pins
    prs_byte_t route_b; // Serial ports
    prs_byte_t route_c; // Timer A waves
    prs_byte_t route_d; // Timer B output

    // Per-channel alternative select
    logic [`PRS_CH_COUNT-1:0] sel;

    // High from the first edge after reset release
    logic was_run;

    // Link between bus slave and registers
    prs_reg_if reg_bus ();

    // Bus slave: handshake, decode, read capture
    prs_avmm_slave #(
        .ADDR_W (ADDR_W)
    ) u_slave (
        .sys_clk         (sys_clk),
        .rst_b           (rst_b),
        .avm_address     (avm_address),
        .avm_read        (avm_read),
        .avm_write       (avm_write),
        .avm_writedata   (avm_writedata),
        .avm_byteenable  (avm_byteenable),
        .avm_readdata    (avm_readdata),
        .avm_waitrequest (avm_waitrequest),
        .regs            (reg_bus)
    );

    // Table and event register; reserved bits dropped
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            route_a <= `PRS_RESET_VAL;
        else if (reg_bus.wr_stb && reg_bus.index == `PRS_IDX_LUT_EVT)
            route_a <= reg_bus.wdata & `PRS_MASK_LUT_EVT;
    end

    // Serial port register
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            route_b <= `PRS_RESET_VAL;
        else if (reg_bus.wr_stb && reg_bus.index == `PRS_IDX_SERIAL)
            route_b <= reg_bus.wdata & `PRS_MASK_SERIAL;
    end

    // Timer A wave register
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            route_c <= `PRS_RESET_VAL;
        else if (reg_bus.wr_stb && reg_bus.index == `PRS_IDX_TIMER_A)
            route_c <= reg_bus.wdata & `PRS_MASK_TIMER_A;
    end

    // Timer B register
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            route_d <= `PRS_RESET_VAL;
        else if (reg_bus.wr_stb && reg_bus.index == `PRS_IDX_TIMER_B)
            route_d <= reg_bus.wdata & `PRS_MASK_TIMER_B;
    end

    // Read mux; stored values already hold zeros in reserved bits
    always_comb
    begin
        case (reg_bus.index)
            `PRS_IDX_LUT_EVT: reg_bus.rdata = route_a;
            `PRS_IDX_SERIAL:  reg_bus.rdata = route_b;
            `PRS_IDX_TIMER_A: reg_bus.rdata = route_c;
            `PRS_IDX_TIMER_B: reg_bus.rdata = route_d;
            default:          reg_bus.rdata = `PRS_RESET_VAL;
        endcase
    end

    // Select per channel from the route fields
    always_comb
    begin
        sel = '0;
        // Logic table outputs
        sel[`PRS_CH_TABLE0] = route_a[`PRS_BIT_TABLE0];
        sel[`PRS_CH_TABLE1] = route_a[`PRS_BIT_TABLE1];
        // Async serial: transmit, receive, clock
        for (int k = `PRS_CH_TXD; k <= `PRS_CH_XCK; k++)
        begin
            sel[k] = route_b[`PRS_BIT_ASYNC];
        end
        // Peripheral port: data out, data in, clock, select
        for (int k = `PRS_CH_MOSI; k <= `PRS_CH_SS; k++)
        begin
            sel[k] = route_b[`PRS_BIT_PERIPH];
        end
        // Two-wire port: data and clock move together
        sel[`PRS_CH_SDA] = route_b[`PRS_BIT_TWO_WIRE];
        sel[`PRS_CH_SCL] = route_b[`PRS_BIT_TWO_WIRE];
        // Waves 0-2: honoured in both timer modes
        for (int k = 0; k < `PRS_WAVE_SPLIT_LO; k++)
        begin
            sel[`PRS_CH_WAVE0 + k] = route_c[k];
        end
        // Waves 3-5: only exist in split mode
        for (int k = `PRS_WAVE_SPLIT_LO; k < `PRS_WAVE_COUNT; k++)
        begin
            sel[`PRS_CH_WAVE0 + k] = route_c[k] & timer_a_split;
        end
        // Timer B output
        sel[`PRS_CH_TIMER_B] = route_d[`PRS_BIT_TIMER_B];
    end

    // One route cell per channel
    genvar ch;
    generate
        for (ch = 0; ch < `PRS_CH_COUNT; ch++)
        begin : g_cell
            prs_route_cell u_cell (
                .sys_clk (sys_clk),
                .rst_b   (rst_b),
                .alt_sel (sel[ch]),
                .fn_out  (fn_out[ch]),
                .fn_oe   (fn_oe[ch]),
                .def_in  (def_pin_in[ch]),
                .alt_in  (alt_pin_in[ch]),
                .fn_in   (fn_in[ch]),
                .def_out (def_pin_out[ch]),
                .def_oe  (def_pin_oe[ch]),
                .alt_out (alt_pin_out[ch]),
                .alt_oe  (alt_pin_oe[ch])
            );
        end
    endgenerate

    // Event pins: driven only while enabled, else released
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            event_pin_out <= '0;
            event_pin_oe <= '0;
        end
        else
        begin
            event_pin_oe <= route_a[`PRS_BIT_EVENT_HI:`PRS_BIT_EVENT_LO];
            event_pin_out <= event_in
                             & route_a[`PRS_BIT_EVENT_HI:`PRS_BIT_EVENT_LO];
        end
    end

    // Run marker, keeps checks off reset-time samples
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            was_run <= 1'b0;
        else
            was_run <= 1'b1;
    end

    // Checks
    default clocking dcb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    // Default pin follows the function, alternative pin idle
    generate
        for (ch = 0; ch < `PRS_CH_COUNT; ch++)
        begin : g_chk
            route_def_a: assert property (
                was_run && !$past(sel[ch]) |->
                    def_pin_oe[ch] == $past(fn_oe[ch])
                    && def_pin_out[ch] == $past(fn_out[ch])
                    && !alt_pin_oe[ch])
                else $error("default pin not following function");
        end
    endgenerate

    // Table 1 on alternative pin
    table1_alt_a: assert property (
        was_run && $past(route_a[`PRS_BIT_TABLE1]) |->
            alt_pin_out[`PRS_CH_TABLE1] == $past(fn_out[`PRS_CH_TABLE1])
            && alt_pin_oe[`PRS_CH_TABLE1] == $past(fn_oe[`PRS_CH_TABLE1])
            && !def_pin_oe[`PRS_CH_TABLE1])
        else $error("table 1 not on alternative pin");

    // Table 0 on alternative pin
    table0_alt_a: assert property (
        was_run && $past(route_a[`PRS_BIT_TABLE0]) |->
            alt_pin_out[`PRS_CH_TABLE0] == $past(fn_out[`PRS_CH_TABLE0])
            && alt_pin_oe[`PRS_CH_TABLE0] == $past(fn_oe[`PRS_CH_TABLE0])
            && !def_pin_oe[`PRS_CH_TABLE0])
        else $error("table 0 not on alternative pin");

    // Event pins enabled by their bits
    event_enable_a: assert property (
        was_run |->
            event_pin_oe == $past(route_a[`PRS_BIT_EVENT_HI:`PRS_BIT_EVENT_LO])
            && (event_pin_out & ~event_pin_oe) == '0)
        else $error("event pin enable wrong");

    // Two-wire data and clock move together
    two_wire_alt_a: assert property (
        was_run |->
            alt_pin_oe[`PRS_CH_SCL:`PRS_CH_SDA] == ($past(fn_oe[`PRS_CH_SCL:`PRS_CH_SDA])
                & {2{$past(route_b[`PRS_BIT_TWO_WIRE])}}))
        else $error("two-wire pins misrouted");

    // Peripheral port group on alternative pins
    periph_alt_a: assert property (
        was_run && $past(route_b[`PRS_BIT_PERIPH]) |->
            alt_pin_oe[`PRS_CH_SS:`PRS_CH_MOSI] == $past(fn_oe[`PRS_CH_SS:`PRS_CH_MOSI])
            && def_pin_oe[`PRS_CH_SS:`PRS_CH_MOSI] == '0)
        else $error("peripheral port misrouted");

    // Async receive taken from the selected pin
    async_rx_pin_a: assert property (
        was_run |->
            fn_in[`PRS_CH_RXD] == ($past(route_b[`PRS_BIT_ASYNC])
                ? $past(alt_pin_in[`PRS_CH_RXD]) : $past(def_pin_in[`PRS_CH_RXD])))
        else $error("async receive from wrong pin");

    // Wave 5 moves only in split mode
    wave5_split_a: assert property (
        was_run |->
            alt_pin_oe[`PRS_CH_WAVE0 + 5] == $past(route_c[5] && timer_a_split
                && fn_oe[`PRS_CH_WAVE0 + 5]))
        else $error("wave 5 routing wrong");

    // Wave 4 moves only in split mode
    wave4_split_a: assert property (
        was_run |->
            alt_pin_oe[`PRS_CH_WAVE0 + 4] == $past(route_c[4] && timer_a_split
                && fn_oe[`PRS_CH_WAVE0 + 4]))
        else $error("wave 4 routing wrong");

    // Wave 3 stays on default pin in normal mode
    wave3_normal_a: assert property (
        was_run && !$past(timer_a_split) |->
            !alt_pin_oe[`PRS_CH_WAVE0 + 3]
            && def_pin_oe[`PRS_CH_WAVE0 + 3] == $past(fn_oe[`PRS_CH_WAVE0 + 3]))
        else $error("wave 3 moved in normal mode");

    // Wave 2 follows its bit in either mode
    wave2_route_a: assert property (
        was_run |->
            alt_pin_oe[`PRS_CH_WAVE0 + 2] == $past(route_c[2]
                && fn_oe[`PRS_CH_WAVE0 + 2]))
        else $error("wave 2 routing wrong");

    // Wave 1 follows its bit in either mode
    wave1_route_a: assert property (
        was_run |->
            alt_pin_out[`PRS_CH_WAVE0 + 1] == $past(route_c[1]
                && fn_out[`PRS_CH_WAVE0 + 1]))
        else $error("wave 1 routing wrong");

    // Wave 0 in split mode still on its bit
    wave0_split_a: assert property (
        was_run && $past(timer_a_split && route_c[0]) |->
            alt_pin_oe[`PRS_CH_WAVE0] == $past(fn_oe[`PRS_CH_WAVE0])
            && !def_pin_oe[`PRS_CH_WAVE0])
        else $error("wave 0 not moved in split mode");

    // Timer B output pin choice
    timer_b_alt_a: assert property (
        was_run |->
            alt_pin_oe[`PRS_CH_TIMER_B] == $past(route_d[`PRS_BIT_TIMER_B]
                && fn_oe[`PRS_CH_TIMER_B]))
        else $error("timer B routing wrong");

    // Serial write keeps only defined bits
    serial_mask_a: assert property (
        avm_write && !avm_waitrequest && avm_address == `PRS_ADDR_SERIAL
            && avm_byteenable[0] |=>
            route_b == ($past(avm_writedata[7:0]) & `PRS_MASK_SERIAL))
        else $error("serial register write wrong");

    // Control A reads with reserved bits zero
    read_reserved_a: assert property (
        avm_read && !avm_waitrequest && avm_address == `PRS_ADDR_LUT_EVT |->
            avm_readdata == {24'h0, route_a}
            && (avm_readdata[7:0] & ~`PRS_MASK_LUT_EVT) == 8'h00)
        else $error("control A read wrong");

    // Answer after one wait cycle, lasts one cycle
    bus_answer_a: assert property (
        (avm_read || avm_write) && avm_waitrequest |=>
            !avm_waitrequest ##1 avm_waitrequest)
        else $error("bus answer timing wrong");

    // Scenarios
    split_wave_c: cover property (
        was_run && timer_a_split && alt_pin_oe[`PRS_CH_WAVE0 + 5]);
    serial_write_c: cover property (
        avm_write && !avm_waitrequest && avm_address == `PRS_ADDR_SERIAL);
    all_events_c: cover property (event_pin_oe == 3'h7);
    async_alt_c: cover property (was_run && alt_pin_oe[`PRS_CH_TXD]);
endmodule
`default_nettype wire

// [tb/prs_periph_model.sv]
/*
 * Peripheral and pin side model: fresh levels on every function and pin line.
 * Assumes sys_clk and rst_b of the pin route unit.
 */
`timescale 1ns/1ps
`default_nettype none
`include "prs_map.svh"
module prs_periph_model (
    input  wire logic                          sys_clk,
    input  wire logic                          rst_b,
    output var logic [`PRS_CH_COUNT-1:0]       fn_out,
    output var logic [`PRS_CH_COUNT-1:0]       fn_oe,
    output var logic [`PRS_CH_COUNT-1:0]       def_pin_in,
    output var logic [`PRS_CH_COUNT-1:0]       alt_pin_in,
    output var logic [`PRS_EVENT_COUNT-1:0]    event_in
);
    logic [31:0] state; // Pattern state
    // New pattern each cycle, so a stale route never matches by luck
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= 32'h1234_5678;
        end
        else
        begin
            state <= state ^ (state << 13) ^ (state >> 7) ^ 32'h9E37_79B9;
        end
    end
    assign fn_out     = state[17:0];
    assign fn_oe      = state[31:14];
    assign def_pin_in = state[24:7];
    assign alt_pin_in = state[27:10];
    assign event_in   = state[30:28];
endmodule
`default_nettype wire

// [tb/prs_pin_route_unit_bench.sv]
/*
 * Bench: register access over Avalon-MM and a per-cycle routing monitor.
 * Assumes prs_pkg, prs_reg_if and the design files are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "prs_map.svh"
module prs_pin_route_unit_bench;
    import prs_pkg::*;
    logic sys_clk = 1'b0;           // 25 MHz clock
    logic rst_b = 1'b0;             // Reset, active low
    logic [3:0] adr = 4'h0;         // Bus address
    logic rd = 1'b0;                // Read request
    logic wr = 1'b0;                // Write request
    prs_word_t wdat = 32'h0;        // Write data
    logic [3:0] ben = 4'hF;         // Byte enables
    prs_word_t rdat;                // Read data
    logic wreq;                     // Wait request
    logic split = 1'b0;             // Timer A split mode
    logic [17:0] fo, foe, fi, di, ai, dpo, dpe, apo, ape, sel;
    logic [2:0] ev, epo, epe;
    prs_byte_t sh [4];              // Shadow of the route registers
    logic [17:0] e_fi, e_dpo, e_dpe, e_apo, e_ape;
    logic [2:0] e_epo, e_epe;
    int up_cnt;                     // Edges since reset release, held at 3
    int fails = 0;
    int checked = 0;
    prs_byte_t q;
    prs_pin_route_unit #(.ADDR_W(4)) u_prs_pin_route_unit (.sys_clk(sys_clk), .rst_b(rst_b),
        .avm_address(adr), .avm_read(rd), .avm_write(wr), .avm_writedata(wdat),
        .avm_byteenable(ben), .avm_readdata(rdat), .avm_waitrequest(wreq),
        .timer_a_split(split), .fn_out(fo), .fn_oe(foe), .fn_in(fi), .def_pin_in(di),
        .alt_pin_in(ai), .def_pin_out(dpo), .def_pin_oe(dpe), .alt_pin_out(apo),
        .alt_pin_oe(ape), .event_in(ev), .event_pin_out(epo), .event_pin_oe(epe));
    prs_periph_model u_prs_periph_model (.sys_clk(sys_clk), .rst_b(rst_b), .fn_out(fo),
        .fn_oe(foe), .def_pin_in(di), .alt_pin_in(ai), .event_in(ev));
    // Clock
    initial
    begin
        forever #20 sys_clk = ~sys_clk;
    end
    // Writable bits per address, zero where unmapped
    function automatic prs_byte_t mask_of(input logic [3:0] a);
        case (a)
            `PRS_ADDR_LUT_EVT: return `PRS_MASK_LUT_EVT;
            `PRS_ADDR_SERIAL:  return `PRS_MASK_SERIAL;
            `PRS_ADDR_TIMER_A: return `PRS_MASK_TIMER_A;
            `PRS_ADDR_TIMER_B: return `PRS_MASK_TIMER_B;
            default:           return 8'h00;
        endcase
    endfunction
    // Verdict and end of run
    task automatic give_verdict();
        if (fails == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // One comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // One bus transfer, held until waitrequest is seen low
    task automatic xfer(input logic w, input logic [3:0] a, input prs_byte_t d,
                        input logic [3:0] be, output prs_byte_t r);
        int n;
        @(posedge sys_clk);
        adr <= a;
        rd <= !w;
        wr <= w;
        wdat <= {24'h0, d};
        ben <= be;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (wreq !== 1'b0 && n < 50);
        // Timed out: counts as a mismatch and ends the run
        if (n >= 50)
        begin
            fails++;
            give_verdict();
        end
        else
        begin
            r = rdat[7:0];
            if (!w)
                chk({8'h0, rdat[31:8]}, 32'h0, "read upper lanes");
            if (w && be[0] && a[1:0] == 2'h0)
                sh[a[3:2]] <= d & mask_of(a);
            rd <= 1'b0;
            wr <= 1'b0;
        end
    endtask
    // Read and compare against the shadow
    task automatic rd_chk(input logic [3:0] a);
        xfer(1'b0, a, 8'h00, 4'hF, q);
        chk({24'h0, q}, {24'h0, (a[1:0] == 2'h0) ? sh[a[3:2]] : 8'h00}, "register read");
    endtask
    // Expected routing from pre-edge inputs and shadow
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            up_cnt = 0;
        else
        begin
            sel[0] = sh[0][4];
            sel[1] = sh[0][5];
            sel[4:2] = {3{sh[1][0]}};
            sel[8:5] = {4{sh[1][2]}};
            sel[10:9] = {2{sh[1][4]}};
            sel[13:11] = sh[2][2:0];
            sel[16:14] = sh[2][5:3] & {3{split}};
            sel[17] = sh[3][0];
            e_fi = (ai & sel) | (di & ~sel);
            e_dpo = fo & ~sel;
            e_dpe = foe & ~sel;
            e_apo = fo & sel;
            e_ape = foe & sel;
            e_epe = sh[0][2:0];
            e_epo = ev & sh[0][2:0];
            if (up_cnt < 3)
                up_cnt++;
        end
    end
    // Compare settled outputs mid-cycle
    always @(negedge sys_clk)
    begin
        if (rst_b && up_cnt >= 2)
        begin
            chk({14'h0, fi}, {14'h0, e_fi}, "fn_in");
            chk({14'h0, dpo}, {14'h0, e_dpo}, "def out");
            chk({14'h0, dpe}, {14'h0, e_dpe}, "def oe");
            chk({14'h0, apo}, {14'h0, e_apo}, "alt out");
            chk({14'h0, ape}, {14'h0, e_ape}, "alt oe");
            chk({29'h0, epo}, {29'h0, e_epo}, "event out");
            chk({29'h0, epe}, {29'h0, e_epe}, "event oe");
        end
    end
    // Main sequence
    initial
    begin
        for (int i = 0; i < 4; i++)
            sh[i] = `PRS_RESET_VAL;
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge sys_clk);
        for (int i = 0; i < 4; i++)
            rd_chk(4'(i * 4));
        for (int i = 0; i < 4; i++)
            xfer(1'b1, 4'(i * 4), 8'hFF, 4'hF, q);
        for (int i = 0; i < 4; i++)
            rd_chk(4'(i * 4));
        xfer(1'b1, 4'h1, 8'hFF, 4'hF, q);
        rd_chk(4'h1);
        xfer(1'b1, 4'h0, 8'h00, 4'hE, q);
        rd_chk(4'h0);
        for (int r = 0; r < 4; r++)
            for (int b = 0; b < 6; b++)
            begin
                xfer(1'b1, 4'(r * 4), 8'(1 << b), 4'hF, q);
                repeat (3) @(posedge sys_clk);
                split <= ~split;
                repeat (3) @(posedge sys_clk);
            end
        rst_b <= 1'b0;
        for (int i = 0; i < 4; i++)
            sh[i] <= `PRS_RESET_VAL;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rd_chk(4'hC);
        repeat (4) @(posedge sys_clk);
        give_verdict();
    end
endmodule
`default_nettype wire
